//--- mpi_pkg.sv
package mpi_pkg;

   // Classes of instruction that reach the memory access stage.
   typedef enum logic [3:0] {
      MPI_OP_OTHER     = 4'h0,
      MPI_OP_MACW      = 4'h1,
      MPI_OP_MACL      = 4'h2,
      MPI_OP_MULSW     = 4'h3,
      MPI_OP_DMULSL    = 4'h4,
      MPI_OP_STORE_REG = 4'h5,
      MPI_OP_STORE_MEM = 4'h6,
      MPI_OP_LOAD_REG  = 4'h7,
      MPI_OP_LOAD_MEM  = 4'h8
   } mpi_op_type;

   // Memory access stage sequencer.
   typedef enum logic [2:0] {
      MPI_ST_IDLE       = 3'h0,
      MPI_ST_PAIR_FIRST  = 3'h1,
      MPI_ST_PAIR_SECOND = 3'h2,
      MPI_ST_STRETCH     = 3'h3,
      MPI_ST_ACCESS      = 3'h4
   } mpi_state_type;

   // Width of the multiplier busy counter.
   localparam int unsigned MPI_CNT_W = 3;

   // Multiplier busy cycles after the final memory access stage.
   localparam logic [2:0] MPI_MACW_BUSY  = 3'h3;
   localparam logic [2:0] MPI_MACL_BUSY  = 3'h4;
   localparam logic [2:0] MPI_MULSW_BUSY = 3'h3;
   localparam logic [2:0] MPI_DMULS_BUSY = 3'h4;

   // A stretched access may start once the busy count is at or below these.
   localparam logic [2:0] MPI_LIM_STORE_MEM = 3'h1;
   localparam logic [2:0] MPI_LIM_OTHER     = 3'h2;

   localparam logic [2:0] MPI_CNT_ZERO = 3'h0;
   localparam logic [2:0] MPI_CNT_ONE  = 3'h1;

endpackage

//--- mpi_busy_counter.sv
`timescale 1ns/100ps
module mpi_busy_counter #(
   parameter int unsigned CNT_W = 3
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstSync_n,
   input  wire logic             clkEn,
   // Load
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] loadVal,
   // State
   output logic      [CNT_W-1:0] count_r,
   output logic                  busy_r
);

   logic [CNT_W-1:0] count_nxt;

   // A load wins over the decrement so back to back multiplies chain cleanly.
   always_comb begin
      count_nxt = count_r;
      if (load) begin
         count_nxt = loadVal;
      end else if (count_r != '0) begin
         count_nxt = count_r - CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         count_r <= '0;
         busy_r  <= 1'b0;
      end else if (clkEn) begin
         count_r <= count_nxt;
         busy_r  <= (count_nxt != '0);
      end
   end

endmodule

//--- mpi_interlock.sv
`timescale 1ns/100ps
// What this block does
// - An accumulator store to memory gets one memory access that reads the multiplier and writes memory.
// - That store, meeting a busy multiplier after a word multiply-accumulate, waits until one cycle past the last busy cycle.
// - An accumulator load from a register gets a multiplier-write access, stretched to end with the multiplier.
// - An accumulator load from memory gets a memory-read and multiplier-write access, stretched likewise.
// - The long multiply-accumulate runs fetch, decode, operate, two memory accesses and four busy cycles.
// - Its second memory access reads the operand and hands the operands to the multiplier.
// - The multiplier stays busy for four cycles after the final access, regardless of slots.
// - The decode of the instruction after a long multiply-accumulate is held for exactly one slot.
// - A fetch contending with either access of the long multiply-accumulate splits the slot as usual.
// - An instruction that does not use the multiplier just proceeds after the one-slot decode hold.
// - An instruction that uses the multiplier, other than a multiply-accumulate, is interlocked against the busy multiplier.
// - The multiplier users are both multiply-accumulates, both signed multiplies and the accumulator loads and stores.
// - The second access of a multiply-accumulate is never stalled by leftover busy cycles.
module mpi_interlock #(
   parameter int unsigned CNT_W = mpi_pkg::MPI_CNT_W
) (
   // Clock, enable and reset
   input  wire logic               clk,
   input  wire logic               clkEn,
   input  wire logic               rst_n,
   // Instruction entering the memory access stage
   input  wire logic               accEnter,
   input  wire mpi_pkg::mpi_op_type accOp,
   // Fetch wants the bus in the next cycle
   input  wire logic               fetchReq,
   // Pipeline control
   output logic                    accReady_r,
   output logic                    holdDecode_r,
   output logic                    holdOperate_r,
   output logic                    busSplit_r,
   // Memory and multiplier strobes
   output logic                    memRead_r,
   output logic                    memWrite_r,
   output logic                    mulRead_r,
   output logic                    mulWrite_r,
   output logic                    mulBusy_r
);
   import mpi_pkg::*;

   logic          rstMeta_r;
   logic          rstSync_n;
   mpi_state_type state_r;
   mpi_state_type state_nxt;
   mpi_op_type    op_r;
   mpi_op_type    op_nxt;
   logic          split_nxt;
   logic          cntLoad;
   logic [CNT_W-1:0] cntLoadVal;
   logic [CNT_W-1:0] count;
   logic          pairAcc;
   logic          acc;

   function automatic logic usesMul(input mpi_op_type op);
      usesMul = (op != MPI_OP_OTHER);
   endfunction

   function automatic logic isMulAcc(input mpi_op_type op);
      isMulAcc = (op == MPI_OP_MACW) || (op == MPI_OP_MACL);
   endfunction

   // Store-to-memory needs the extra state past the busy period.
   function automatic logic needStretch(input mpi_op_type op, input logic [CNT_W-1:0] cnt);
      if (op == MPI_OP_STORE_MEM) begin
         needStretch = cnt > CNT_W'(MPI_LIM_STORE_MEM);
      end else begin
         needStretch = cnt > CNT_W'(MPI_LIM_OTHER);
      end
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_n <= rstMeta_r;
      end
   end

   mpi_busy_counter #(
      .CNT_W (CNT_W)
   ) u_busy (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .clkEn     (clkEn),
      .load      (cntLoad),
      .loadVal   (cntLoadVal),
      .count_r   (count),
      .busy_r    (mulBusy_r)
   );

   always_comb begin
      state_nxt  = state_r;
      op_nxt     = op_r;
      split_nxt  = 1'b0;
      cntLoad    = 1'b0;
      cntLoadVal = '0;
      unique case (state_r)
         MPI_ST_IDLE: begin
            if (accEnter) begin
               op_nxt = accOp;
               if (isMulAcc(accOp)) begin
                  state_nxt = MPI_ST_PAIR_FIRST;
                  split_nxt = fetchReq;
               end else if (usesMul(accOp)) begin
                  // Multiplier users stretch until the busy count is at or below their limit.
                  state_nxt = needStretch(accOp, count) ? MPI_ST_STRETCH
                                                       : MPI_ST_ACCESS;
               end
            end
         end
         MPI_ST_PAIR_FIRST: begin
            if (!busSplit_r) begin
               state_nxt = MPI_ST_PAIR_SECOND;
               split_nxt = fetchReq;
            end
         end
         MPI_ST_PAIR_SECOND: begin
            // No busy check here: leftover busy cycles never stall this access.
            if (!busSplit_r) begin
               state_nxt  = MPI_ST_IDLE;
               cntLoad    = 1'b1;
               cntLoadVal = (op_r == MPI_OP_MACL) ? CNT_W'(MPI_MACL_BUSY) : CNT_W'(MPI_MACW_BUSY);
            end
         end
         MPI_ST_STRETCH: begin
            if (!needStretch(op_r, count)) begin
               state_nxt = MPI_ST_ACCESS;
            end
         end
         MPI_ST_ACCESS: begin
            state_nxt = MPI_ST_IDLE;
            if (op_r == MPI_OP_MULSW) begin
               cntLoad    = 1'b1;
               cntLoadVal = CNT_W'(MPI_MULSW_BUSY);
            end else if (op_r == MPI_OP_DMULSL) begin
               cntLoad    = 1'b1;
               cntLoadVal = CNT_W'(MPI_DMULS_BUSY);
            end
         end
         default: begin
            state_nxt = MPI_ST_IDLE;
         end
      endcase
      pairAcc = ((state_nxt == MPI_ST_PAIR_FIRST) || (state_nxt == MPI_ST_PAIR_SECOND)) && !split_nxt;
      acc    = (state_nxt == MPI_ST_ACCESS);
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_r    <= MPI_ST_IDLE;
         op_r       <= MPI_OP_OTHER;
         busSplit_r <= 1'b0;
      end else if (clkEn) begin
         state_r    <= state_nxt;
         op_r       <= op_nxt;
         busSplit_r <= split_nxt;
      end
   end

   // Strobes are registered from the next state so they line up with it.
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         memRead_r  <= 1'b0;
         memWrite_r <= 1'b0;
         mulRead_r  <= 1'b0;
         mulWrite_r <= 1'b0;
      end else if (clkEn) begin
         memRead_r  <= pairAcc || (acc && (op_nxt == MPI_OP_LOAD_MEM));
         memWrite_r <= acc && (op_nxt == MPI_OP_STORE_MEM);
         mulRead_r  <= acc && ((op_nxt == MPI_OP_STORE_REG) || (op_nxt == MPI_OP_STORE_MEM));
         mulWrite_r <= (pairAcc && (state_nxt == MPI_ST_PAIR_SECOND))
                       || (acc && (op_nxt != MPI_OP_STORE_REG)
                           && (op_nxt != MPI_OP_STORE_MEM));
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         accReady_r    <= 1'b1;
         holdDecode_r  <= 1'b0;
         holdOperate_r <= 1'b0;
      end else if (clkEn) begin
         accReady_r    <= (state_nxt == MPI_ST_IDLE);
         // The one-slot decode hold is tied to entry, so a split does not lengthen it.
         holdDecode_r  <= (state_nxt == MPI_ST_STRETCH)
                          || ((state_r == MPI_ST_IDLE) && (state_nxt == MPI_ST_PAIR_FIRST)
                              && (op_nxt == MPI_OP_MACL));
         holdOperate_r <= (state_nxt == MPI_ST_STRETCH);
      end
   end

   property p_store_one_past;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_ACCESS) && (op_r == MPI_OP_STORE_MEM) |-> (count == '0);
   endproperty
   a_store_one_past: assert property (p_store_one_past) else $error("store access overlaps busy multiplier");

   property p_store_strobes;
      @(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_ACCESS) && (op_r == MPI_OP_STORE_MEM) |-> memWrite_r && mulRead_r;
   endproperty
   a_store_strobes: assert property (p_store_strobes) else $error("store access lacks strobes");

   property p_load_reg_ends;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_ACCESS) && (op_r == MPI_OP_LOAD_REG) && ($past(state_r) == MPI_ST_STRETCH)
      |-> (count == CNT_W'(MPI_CNT_ONE)) && mulWrite_r;
   endproperty
   a_load_reg_ends: assert property (p_load_reg_ends) else $error("load access not on last busy cycle");

   property p_load_mem_strobes;
      @(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_ACCESS) && (op_r == MPI_OP_LOAD_MEM) |-> memRead_r && mulWrite_r && !memWrite_r;
   endproperty
   a_load_mem_strobes: assert property (p_load_mem_strobes) else $error("memory load strobes wrong");

   property p_pair_first_then_second;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_PAIR_FIRST) && !busSplit_r ##1 clkEn |-> (state_r == MPI_ST_PAIR_SECOND);
   endproperty
   a_pair_first_then_second: assert property (p_pair_first_then_second) else $error("second access skipped");

   property p_pair_second_strobes;
      @(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_PAIR_SECOND) && !busSplit_r |-> memRead_r && mulWrite_r;
   endproperty
   a_pair_second_strobes: assert property (p_pair_second_strobes) else $error("operands not handed over");

   // A following multiply-accumulate may reload the counter early, so such runs are left out.
   property p_long_busy_count;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_PAIR_SECOND) && !busSplit_r && (op_r == MPI_OP_MACL)
      ##1 (clkEn && !cntLoad) [*3] ##1 clkEn
      |-> (count == CNT_W'(MPI_CNT_ONE)) && $past(mulBusy_r, 3);
   endproperty
   a_long_busy_count: assert property (p_long_busy_count) else $error("long busy period not four cycles");

   property p_decode_one_slot;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_PAIR_FIRST) && (op_r == MPI_OP_MACL) && ($past(state_r) == MPI_ST_IDLE)
      |-> holdDecode_r ##1 (clkEn -> !holdDecode_r);
   endproperty
   a_decode_one_slot: assert property (p_decode_one_slot) else $error("decode hold not one slot");

   property p_split_one_cycle;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      busSplit_r ##1 clkEn |-> !busSplit_r && (state_r == $past(state_r));
   endproperty
   a_split_one_cycle: assert property (p_split_one_cycle) else $error("split cycle malformed");

   property p_second_no_stall;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_PAIR_SECOND) && !busSplit_r ##1 clkEn |-> (state_r == MPI_ST_IDLE);
   endproperty
   a_second_no_stall: assert property (p_second_no_stall) else $error("second access stalled");

   property p_stretch_holds;
      @(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_STRETCH) |-> holdDecode_r && holdOperate_r && !accReady_r;
   endproperty
   a_stretch_holds: assert property (p_stretch_holds) else $error("younger stages not held");

   property p_other_passes;
      @(posedge clk) disable iff (!rstSync_n || !clkEn)
      (state_r == MPI_ST_IDLE) && accEnter && (accOp == MPI_OP_OTHER) ##1 clkEn |-> accReady_r;
   endproperty
   a_other_passes: assert property (p_other_passes) else $error("plain instruction stalled");

   c_store_stretch: cover property (@(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_STRETCH) && (op_r == MPI_OP_STORE_MEM) ##1 (state_r == MPI_ST_ACCESS));
   c_long_pair: cover property (@(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_PAIR_SECOND) && (op_r == MPI_OP_MACL) && !busSplit_r);
   c_split: cover property (@(posedge clk) disable iff (!rstSync_n)
      busSplit_r && (state_r == MPI_ST_PAIR_SECOND));
   c_load_stretch: cover property (@(posedge clk) disable iff (!rstSync_n)
      (state_r == MPI_ST_STRETCH) && (op_r == MPI_OP_LOAD_MEM));

endmodule

//--- mpi_pipe_model.sv
`timescale 1ns/100ps
module mpi_pipe_model (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Bench control
   input  wire logic               enable,
   input  wire logic               useFixed,
   input  wire mpi_pkg::mpi_op_type fixedOp,
   input  wire logic [31:0]        rnd,
   // Interlock side
   input  wire logic               clkEn,
   input  wire logic               accReady_r,
   output logic                    accEnter,
   output mpi_pkg::mpi_op_type     accOp,
   output logic                    fetchReq
);
   import mpi_pkg::*;
   logic taken;
   assign taken = accEnter && accReady_r && clkEn;
   // An instruction waits until it is taken; on release, and on each cycle while disabled, the class lines
   // take a random class, so a stale class can never pass for a valid request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accEnter <= 1'b0;
         accOp    <= MPI_OP_OTHER;
         fetchReq <= 1'b0;
      end else begin
         fetchReq <= rnd[7];
         if (taken || !enable) begin
            accEnter <= 1'b0;
            accOp    <= mpi_op_type'(rnd[11:8] % 4'h9);
         end else if (!accEnter && (useFixed || rnd[2:0] != 3'h0)) begin
            accEnter <= 1'b1;
            accOp    <= useFixed ? fixedOp : mpi_op_type'(rnd[11:8] % 4'h9);
         end
      end
   end
endmodule

//--- multiplier_pipeline_interlock_tb.sv
`timescale 1ns/100ps
module multiplier_pipeline_interlock_tb;
   import mpi_pkg::*;
   localparam logic [2:0] S_IDLE = 3'h0, S_SPL1 = 3'h1, S_ACC1 = 3'h2, S_SPL2 = 3'h3;
   localparam logic [2:0] S_ACC2 = 3'h4, S_STR = 3'h5, S_ACC = 3'h6;
   logic        clk, rst_n, clkEn, enable, useFixed, chkOn;
   logic [31:0] rnd;
   mpi_op_type  fixedOp, accOp, eOp;
   logic        accEnter, fetchReq, accReady_r, holdDecode_r, holdOperate_r, busSplit_r;
   logic        memRead_r, memWrite_r, mulRead_r, mulWrite_r, mulBusy_r;
   logic [2:0]  eSt, eCnt;
   logic        eSplit, acc, hdFirst, stMem, stReg, ldMem, mulIn;
   int          n_mismatch = 0;
   int          checks = 0;
   mpi_op_type  seq[18] = '{MPI_OP_MACL, MPI_OP_STORE_MEM, MPI_OP_MACW, MPI_OP_STORE_MEM,
      MPI_OP_MACW, MPI_OP_LOAD_REG, MPI_OP_MACL, MPI_OP_LOAD_MEM, MPI_OP_MACW, MPI_OP_MACW,
      MPI_OP_MACL, MPI_OP_MULSW, MPI_OP_STORE_REG, MPI_OP_DMULSL, MPI_OP_LOAD_REG,
      MPI_OP_OTHER, MPI_OP_MACL, MPI_OP_OTHER};

   mpi_interlock u_dut (.clk(clk), .clkEn(clkEn), .rst_n(rst_n), .accEnter(accEnter),
      .accOp(accOp), .fetchReq(fetchReq), .accReady_r(accReady_r), .holdDecode_r(holdDecode_r),
      .holdOperate_r(holdOperate_r), .busSplit_r(busSplit_r), .memRead_r(memRead_r),
      .memWrite_r(memWrite_r), .mulRead_r(mulRead_r), .mulWrite_r(mulWrite_r),
      .mulBusy_r(mulBusy_r));

   mpi_pipe_model u_pipe (.clk(clk), .rst_n(rst_n), .enable(enable), .useFixed(useFixed),
      .fixedOp(fixedOp), .rnd(rnd), .clkEn(clkEn), .accReady_r(accReady_r),
      .accEnter(accEnter), .accOp(accOp), .fetchReq(fetchReq));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // A store to memory must wait one cycle longer than the other multiplier users.
   function automatic logic [2:0] limit(input mpi_op_type op);
      return (op == MPI_OP_STORE_MEM) ? MPI_LIM_STORE_MEM : MPI_LIM_OTHER;
   endfunction

   task automatic check(input string name, input logic v, input logic e);
      checks++;
      if (v !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %b, seen %b", name, e, v);
      end
   endtask

   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic run_op(input mpi_op_type op);
      int n;
      fixedOp <= op;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(accEnter && accReady_r && clkEn && accOp == op) && n < 200);
      if (n >= 200) begin
         n_mismatch++;
         close_out;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      rnd   <= lfsr(rnd);
      clkEn <= (rnd[15:13] != 3'h0);
   end

   // Reference of the interlock, stepping only on enabled edges like the design.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eSt    <= S_IDLE;
         eCnt   <= 3'h0;
         eSplit <= 1'b0;
         eOp    <= MPI_OP_OTHER;
      end else if (clkEn) begin
         eCnt <= (eCnt != 3'h0) ? eCnt - 3'h1 : 3'h0;
         case (eSt)
            S_IDLE: if (accEnter && accOp != MPI_OP_OTHER) begin
               eOp    <= accOp;
               eSplit <= fetchReq;
               if (accOp == MPI_OP_MACW || accOp == MPI_OP_MACL)
                  eSt <= fetchReq ? S_SPL1 : S_ACC1;
               else
                  eSt <= (eCnt <= limit(accOp)) ? S_ACC : S_STR;
            end
            S_SPL1: eSt <= S_ACC1;
            S_ACC1: eSt <= fetchReq ? S_SPL2 : S_ACC2;
            S_SPL2: eSt <= S_ACC2;
            S_ACC2: begin
               eSt  <= S_IDLE;
               eCnt <= (eOp == MPI_OP_MACL) ? MPI_MACL_BUSY : MPI_MACW_BUSY;
            end
            S_STR: if (eCnt <= limit(eOp)) eSt <= S_ACC;
            S_ACC: begin
               eSt <= S_IDLE;
               if (eOp == MPI_OP_MULSW) eCnt <= MPI_MULSW_BUSY;
               else if (eOp == MPI_OP_DMULSL) eCnt <= MPI_DMULS_BUSY;
            end
            default: eSt <= S_IDLE;
         endcase
      end
   end

   // The one-slot decode hold sits in the first cycle after entry, split or not.
   always @(negedge clk) begin
      if (chkOn) begin
         acc     = (eSt == S_ACC);
         hdFirst = (eOp == MPI_OP_MACL) && (eSplit ? (eSt == S_SPL1) : (eSt == S_ACC1));
         stMem   = acc && (eOp == MPI_OP_STORE_MEM);
         stReg   = acc && (eOp == MPI_OP_STORE_REG);
         ldMem   = acc && (eOp == MPI_OP_LOAD_MEM);
         mulIn   = acc && (eOp == MPI_OP_LOAD_REG || eOp == MPI_OP_MULSW || eOp == MPI_OP_DMULSL);
         check("accReady_r", accReady_r, eSt == S_IDLE);
         check("busSplit_r", busSplit_r, eSt == S_SPL1 || eSt == S_SPL2);
         check("holdOperate_r", holdOperate_r, eSt == S_STR);
         check("holdDecode_r", holdDecode_r, eSt == S_STR || hdFirst);
         check("mulBusy_r", mulBusy_r, eCnt != 3'h0);
         check("memRead_r", memRead_r, eSt == S_ACC1 || eSt == S_ACC2 || ldMem);
         check("memWrite_r", memWrite_r, stMem);
         check("mulRead_r", mulRead_r, stMem || stReg);
         check("mulWrite_r", mulWrite_r, eSt == S_ACC2 || ldMem || mulIn);
      end
   end

   initial begin
      rnd      = 32'h0000_bc3b;
      rst_n    = 1'b0;
      clkEn    = 1'b0;
      enable   = 1'b0;
      useFixed = 1'b1;
      fixedOp  = MPI_OP_OTHER;
      chkOn    = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chkOn <= 1'b1;
      repeat (3) @(posedge clk);
      enable <= 1'b1;
      foreach (seq[i]) run_op(seq[i]);
      useFixed <= 1'b0;
      repeat (3000) @(posedge clk);
      // A second reset lands while traffic is in flight.
      enable <= 1'b0;
      rst_n  <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      enable <= 1'b1;
      repeat (3000) @(posedge clk);
      close_out;
   end
endmodule
